// [bdg_buf_if.sv]
// interface: valid/ready word path through the two-entry buffer
`timescale 1ns/100ps
`default_nettype none
interface bdg_buf_if;
  logic inValid;
  logic inReady;
  logic [31:0] inData;
  logic outValid;
  logic outReady;
  logic [31:0] outData;
  modport store (input inValid, inData, outReady, output inReady, outValid, outData);
  modport user (output inValid, inData, outReady, input inReady, outValid, outData);
endinterface
`default_nettype wire

// [bdg_buffer.sv]
// module: two-entry word buffer with valid/ready on both sides
`timescale 1ns/100ps
`default_nettype none
module bdg_buffer
  import bdg_pkg::*;
(
  input wire logic clk, // system clock
  input wire logic rstn, // sync reset, active low
  bdg_buf_if.store bus // fill and drain sides
);
  logic [31:0] mem_ff [2];
  logic wrPtr_ff;
  logic rdPtr_ff;
  logic [1:0] count_ff;
  logic doWrite;
  logic doRead;

  // honest full and empty from the entry count
  assign bus.inReady = (count_ff != 2'h2);
  assign bus.outValid = (count_ff != 2'h0);
  assign bus.outData = mem_ff[rdPtr_ff];
  assign doWrite = bus.inValid && bus.inReady;
  assign doRead = bus.outValid && bus.outReady;

  // storage, no reset needed on data
  always_ff @(posedge clk) begin
    if (doWrite) begin
      mem_ff[wrPtr_ff] <= bus.inData;
    end
  end

  // pointers and count
  always_ff @(posedge clk) begin
    if (!rstn) begin
      wrPtr_ff <= 1'b0;
      rdPtr_ff <= 1'b0;
      count_ff <= 2'h0;
    end else begin
      wrPtr_ff <= wrPtr_ff ^ doWrite;
      rdPtr_ff <= rdPtr_ff ^ doRead;
      count_ff <= count_ff + {1'b0, doWrite} - {1'b0, doRead};
    end
  end
endmodule
`default_nettype wire

// [bdg_ctrl_model.sv]
// model: dram controller answering the glue's row requests
`timescale 1ns/100ps
`default_nettype none
module bdg_ctrl_model (
  input wire logic clk, // system clock
  input wire logic rstn, // sync reset, active low
  input wire logic accessRequestN, // row request from glue
  input wire logic columnIncrement, // next column
  input wire logic slow, // late acknowledge
  output logic dataTransferAckN, // data ack to glue
  output logic [31:0] dramData // read data
);
  logic [3:0] cnt_ff;
  logic [7:0] col_ff;
  logic [7:0] patt_ff;
  // ack after the row strobe, late when slow; column follows increments
  always_ff @(posedge clk) begin
    patt_ff <= rstn ? patt_ff + 8'h1 : 8'h0;
    if (!rstn || accessRequestN) begin
      cnt_ff <= 4'h0;
      col_ff <= 8'h0;
      dataTransferAckN <= 1'b1;
    end else begin
      if (cnt_ff != 4'hF) cnt_ff <= cnt_ff + 4'h1;
      dataTransferAckN <= !(cnt_ff >= (slow ? 4'h6 : 4'h0));
      if (columnIncrement) col_ff <= col_ff + 8'h1;
    end
  end
  // data only valid while the row is open; a moving pattern otherwise
  assign dramData = accessRequestN ? {4{patt_ff}} : {24'hC0DE00, col_ff};
endmodule
`default_nettype wire

// [bdg_glue.sv]
// module: processor-to-dram-controller burst page-mode glue
// How it works
// RULE1: option one: four single, two burst waits
// RULE2: option two: four single, one burst wait
// RULE3: after idle mid-burst, next access one wait
// RULE4: row held after access until new request
// RULE5: burst request fetches next word, page mode
// RULE6: burst ack low unless refresh or new
// RULE7: arbitrate access against refresh, stall with waits
// RULE8: row low four, precharge three clocks
// RULE9: configure three precharge clocks at 20 MHz
// RULE10: ack after access row strobe, driven out
// RULE11: controller adds no burst wait states
// RULE12: address pipelining disabled for bursts
// RULE13: refresh prescaler code zero divides ten
// RULE14: strobe groups chosen by bank select
// RULE15: row address setup 0, hold 15 ns
// RULE16: write column strobe delayed one clock
// RULE17: address input mode suits column increment
// RULE18: ready term registered, ends each access
// RULE19: end access only after ready or idle
// RULE20: refresh and ack pass flip-flops first
// RULE21: reset abandons access, outputs inactive; instrBurstAckN stays low in reset unless a new request is decoded
// RULE22: column increment once per burst word
`timescale 1ns/100ps
`default_nettype none
module bdg_glue
  import bdg_pkg::*;
(
  input wire logic clk, // 20 MHz system clock
  input wire logic rstn, // sync reset, active low
  input wire logic burstOption, // 0: two burst waits, 1: one
  input wire logic chipSelectN, // memory select, active low
  input wire logic instrRequestN, // processor access request
  input wire logic instrBurstRequestN, // processor burst request
  input wire logic accessIsWrite, // current access writes
  input wire logic refreshRequestN, // controller refresh request
  input wire logic dataTransferAckN, // controller data ack
  input wire logic delayClockIn, // delay clock pin
  input wire logic [31:0] dramData, // read data from dram
  output logic accessRequestN, // row access request
  output logic addrStrobeN, // controller address strobe
  output logic instrReadyN, // ready to processor
  output logic instrBurstAckN, // burst ack to processor
  output logic columnIncrement, // controller column increment
  output logic earlyCasN, // column strobe toggle
  output logic columnAddrSelect, // row/column address switch
  output logic refreshTick, // refresh timebase pulse
  output logic [MODE_W-1:0] modeProgram, // controller programming
  output logic procDataValid, // word to processor valid
  input wire logic procDataReady, // processor takes word
  output logic [31:0] procData // word to processor
);
  bdg_state_t state_ff, nxt_state;
  logic [2:0] waitCnt_ff, nxt_waitCnt;
  logic [2:0] rasCnt_ff;
  logic [2:0] prechCnt_ff, nxt_prechCnt;
  logic refMeta_ff, refSync_ff, ackMeta_ff, ackSync_ff;
  logic dlyMeta_ff, dlySync_ff, dlyLast_ff;
  logic accessN_ff, nxt_accessN;
  logic readyN_ff, column_increment_ff, ecasN_ff, colSel_ff, tick_ff;
  logic ackSeen_ff, burstWord_ff, nxt_burstWord, idleGap_ff, nxt_idleGap;
  logic casDelay_ff;
  logic [3:0] divCnt_ff;
  logic [MODE_W-1:0] modeWord, mode_ff;
  logic newReq, burstReq, refPend, rasMet, readyTerm, rowRelease, burstStart, singleStart;
  logic [2:0] burstWaits;
  logic [3:0] divisor;
  logic dlyEdge, divWrap;
  bdg_buf_if bufBus ();

  bdg_buffer u_buffer (
    .clk(clk),
    .rstn(rstn),
    .bus(bufBus.store)
  );

  // two flip-flops before any state logic reads controller outputs
  always_ff @(posedge clk) begin
    if (!rstn) begin
      refMeta_ff <= 1'b1;
      refSync_ff <= 1'b1;
      ackMeta_ff <= 1'b1;
      ackSync_ff <= 1'b1;
      dlyMeta_ff <= 1'b0;
      dlySync_ff <= 1'b0;
      dlyLast_ff <= 1'b0;
    end else begin
      refMeta_ff <= refreshRequestN; // RULE20
      refSync_ff <= refMeta_ff; // RULE20
      ackMeta_ff <= dataTransferAckN; // RULE20
      ackSync_ff <= ackMeta_ff; // RULE20
      dlyMeta_ff <= delayClockIn;
      dlySync_ff <= dlyMeta_ff;
      dlyLast_ff <= dlySync_ff;
    end
  end

  // request decode and arbitration terms
  assign newReq = !instrRequestN && !chipSelectN;
  assign burstReq = !instrBurstRequestN;
  assign refPend = !refSync_ff; // RULE7
  assign rasMet = (rasCnt_ff >= RAS_LOW_CYC - 3'h1); // RULE8
  // a full buffer withholds ready, so a stalled reader loses no word
  assign readyTerm = (state_ff == ST_WAIT) && (waitCnt_ff == 3'h0) && ackSeen_ff
                     && bufBus.inReady; // RULE7
  assign rowRelease = (state_ff == ST_OPEN) && (newReq || refPend) && rasMet; // RULE19
  assign burstStart = (state_ff == ST_OPEN) && !rowRelease && burstReq && !newReq
                      && !refPend; // RULE5
  assign singleStart = (state_ff == ST_IDLE) && newReq && !refPend; // RULE7
  assign burstWaits = burstOption ? WAIT_BURST_OPT2 : WAIT_BURST_OPT1; // RULE2

  // next state of the access sequencer
  always_comb begin
    nxt_state = state_ff;
    nxt_waitCnt = waitCnt_ff;
    nxt_prechCnt = prechCnt_ff;
    nxt_accessN = accessN_ff;
    nxt_burstWord = burstWord_ff;
    nxt_idleGap = idleGap_ff;
    unique case (state_ff)
      ST_IDLE: begin
        if (singleStart) begin
          nxt_state = ST_WAIT;
          nxt_waitCnt = WAIT_SINGLE; // RULE1
          nxt_accessN = 1'b0;
          nxt_burstWord = 1'b0;
          nxt_idleGap = 1'b0;
        end
      end
      ST_WAIT: begin
        if (readyTerm) begin
          nxt_state = ST_OPEN;
        end else if (waitCnt_ff != 3'h0) begin
          nxt_waitCnt = waitCnt_ff - 3'h1; // RULE7
        end
      end
      ST_OPEN: begin
        if (rowRelease) begin
          nxt_state = ST_PRECH;
          nxt_prechCnt = PRECHARGE_CYC - 3'h1; // RULE8
          nxt_accessN = 1'b1; // RULE4
        end else if (burstStart) begin
          nxt_state = ST_WAIT;
          nxt_waitCnt = idleGap_ff ? WAIT_AFTER_IDLE : burstWaits; // RULE3
          nxt_burstWord = 1'b1;
          nxt_idleGap = 1'b0;
        end else begin
          nxt_idleGap = 1'b1; // RULE3
        end
      end
      ST_PRECH: begin
        if (prechCnt_ff == 3'h0) begin
          nxt_state = ST_IDLE;
        end else begin
          nxt_prechCnt = prechCnt_ff - 3'h1; // RULE8
        end
      end
    endcase
  end

  // sequencer registers; reset abandons any access
  always_ff @(posedge clk) begin
    if (!rstn) begin
      state_ff <= ST_IDLE; // RULE21
      waitCnt_ff <= 3'h0;
      prechCnt_ff <= 3'h0;
      accessN_ff <= 1'b1; // RULE21
      burstWord_ff <= 1'b0;
      idleGap_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      waitCnt_ff <= nxt_waitCnt;
      prechCnt_ff <= nxt_prechCnt;
      accessN_ff <= nxt_accessN;
      burstWord_ff <= nxt_burstWord;
      idleGap_ff <= nxt_idleGap;
    end
  end

  // row low time, ack seen once per row, address switch after hold
  always_ff @(posedge clk) begin
    if (!rstn || accessN_ff) begin
      rasCnt_ff <= 3'h0;
      ackSeen_ff <= 1'b0;
      colSel_ff <= 1'b0;
    end else begin
      rasCnt_ff <= (rasCnt_ff == 3'h7) ? rasCnt_ff : rasCnt_ff + 3'h1;
      ackSeen_ff <= ackSeen_ff || !ackSync_ff; // RULE10
      colSel_ff <= (rasCnt_ff >= ROW_HOLD_CYC - 3'h1); // RULE15
    end
  end

  // ready, column increment and early column strobe
  always_ff @(posedge clk) begin
    if (!rstn) begin
      readyN_ff <= 1'b1; // RULE21
      column_increment_ff <= 1'b0;
      ecasN_ff <= 1'b1; // RULE21
      casDelay_ff <= 1'b0;
    end else begin
      readyN_ff <= !readyTerm; // RULE18
      column_increment_ff <= readyTerm && burstReq; // RULE22
      casDelay_ff <= burstStart && accessIsWrite && mode_ff[C9_POS]; // RULE16
      ecasN_ff <= !((state_ff == ST_WAIT) && burstWord_ff && !casDelay_ff
                    && !readyTerm); // RULE5
    end
  end

  // refresh timebase: delay clock edges divided by the prescaler code
  assign divisor = (mode_ff[C0_POS +: 3] == REF_DIV_CODE) ? REF_DIV_TEN : REF_DIV_OTHER;
  assign dlyEdge = dlySync_ff && !dlyLast_ff;
  assign divWrap = dlyEdge && (divCnt_ff == divisor - 4'h1); // RULE13
  always_ff @(posedge clk) begin
    if (!rstn) begin
      divCnt_ff <= 4'h0;
      tick_ff <= 1'b0;
    end else begin
      divCnt_ff <= divWrap ? 4'h0 : divCnt_ff + {3'h0, dlyEdge}; // RULE13
      tick_ff <= divWrap;
    end
  end

  // controller programming word, loaded after reset
  always_comb begin
    modeWord = MODE_RESET;
    modeWord[R0_POS +: 2] = ROW_TIMING_VAL; // RULE8
    modeWord[R2_POS +: 2] = ACK_TIMING_VAL; // RULE10
    modeWord[R7_POS] = ACK_OUT_VAL; // RULE10
    modeWord[R4_POS +: 2] = BURST_WAIT_VAL; // RULE11
    modeWord[R8_POS] = PIPE_DIS_VAL; // RULE12
    modeWord[C0_POS +: 3] = REF_DIV_CODE; // RULE13
    modeWord[C4_POS +: 3] = STROBE_GROUP_VAL; // RULE14
    modeWord[C7_POS] = ROW_SETUP_VAL; // RULE15
    modeWord[C8_POS] = ROW_HOLD_VAL; // RULE15
    modeWord[C9_POS] = WRITE_CAS_VAL; // RULE16
    modeWord[B0_POS] = ADDR_MODE_VAL; // RULE17
    modeWord[B1_POS] = BANK_SEL_VAL; // RULE14
  end
  always_ff @(posedge clk) begin
    if (!rstn) begin
      mode_ff <= MODE_RESET;
    end else begin
      mode_ff <= modeWord;
    end
  end

  // data path through the buffer, captured with the ready term
  assign bufBus.inValid = readyTerm;
  assign bufBus.inData = dramData;
  assign bufBus.outReady = procDataReady;
  assign procDataValid = bufBus.outValid;
  assign procData = bufBus.outData;

  // outputs
  assign accessRequestN = accessN_ff; // RULE4
  assign addrStrobeN = accessN_ff;
  assign instrReadyN = readyN_ff; // RULE18
  assign columnIncrement = column_increment_ff;
  assign earlyCasN = ecasN_ff;
  assign columnAddrSelect = colSel_ff;
  assign refreshTick = tick_ff;
  assign modeProgram = mode_ff;
  // burst ack is a handshake term, so it stays combinational
  assign instrBurstAckN = refPend || newReq; // RULE6

  // checks
  property p_single_wait;
    @(posedge clk) disable iff (!rstn) singleStart |=> (waitCnt_ff == 3'h4);
  endproperty
  a_single_wait: assert property (p_single_wait) else $error("single wait load wrong"); // RULE1
  property p_burst_opt1;
    @(posedge clk) disable iff (!rstn)
      (burstStart && !burstOption && !idleGap_ff) |=> (waitCnt_ff == 3'h2);
  endproperty
  a_burst_opt1: assert property (p_burst_opt1) else $error("burst wait opt1 wrong"); // RULE1
  property p_burst_opt2;
    @(posedge clk) disable iff (!rstn)
      (burstStart && burstOption) |=> (waitCnt_ff == 3'h1);
  endproperty
  a_burst_opt2: assert property (p_burst_opt2) else $error("burst wait opt2 wrong"); // RULE2
  property p_idle_gap;
    @(posedge clk) disable iff (!rstn) (burstStart && idleGap_ff) |=> (waitCnt_ff == 3'h1);
  endproperty
  a_idle_gap: assert property (p_idle_gap) else $error("post-idle wait wrong"); // RULE3
  property p_row_held;
    @(posedge clk) disable iff (!rstn)
      (state_ff == ST_OPEN && !newReq && !refPend) |=> !accessRequestN;
  endproperty
  a_row_held: assert property (p_row_held) else $error("row released early"); // RULE4
  property p_burst_ack;
    @(posedge clk) disable iff (!rstn)
      ($past(refreshRequestN, 2) && (instrRequestN || chipSelectN)) |-> !instrBurstAckN;
  endproperty
  a_burst_ack: assert property (p_burst_ack) else $error("burst ack high"); // RULE6
  property p_precharge;
    @(posedge clk) disable iff (!rstn) $rose(accessRequestN) |-> accessRequestN [*3];
  endproperty
  a_precharge: assert property (p_precharge) else $error("precharge too short"); // RULE8
  property p_ready;
    @(posedge clk) disable iff (!rstn)
      readyTerm |=> !instrReadyN ##1 (instrReadyN || state_ff == ST_WAIT);
  endproperty
  a_ready: assert property (p_ready) else $error("ready not registered"); // RULE18
  property p_column_increment;
    @(posedge clk) disable iff (!rstn)
      (readyTerm && burstReq) |=> (columnIncrement && !instrReadyN);
  endproperty
  a_column_increment: assert property (p_column_increment) else $error("column increment misaligned"); // RULE22
  property p_reset;
    @(posedge clk) !rstn |=> (accessRequestN && instrReadyN && earlyCasN);
  endproperty
  a_reset: assert property (p_reset) else $error("reset left outputs active"); // RULE21
endmodule
`default_nettype wire

// [bdg_pkg.sv]
// package: constants for the burst page-mode dram glue
package bdg_pkg;
  // clock and timing figures
  localparam int CLK_PERIOD_NS = 50;
  localparam int ROW_HOLD_NS = 15;
  localparam int ROW_SETUP_NS = 0;
  localparam int ROW_HOLD_CYC_I = (ROW_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [2:0] ROW_HOLD_CYC = (ROW_HOLD_CYC_I < 1) ? 3'h1 : ROW_HOLD_CYC_I[2:0];
  localparam logic [2:0] RAS_LOW_CYC = 3'h4;
  localparam logic [2:0] PRECHARGE_CYC = 3'h3;
  // wait states per access kind
  localparam logic [2:0] WAIT_SINGLE = 3'h4;
  localparam logic [2:0] WAIT_BURST_OPT1 = 3'h2;
  localparam logic [2:0] WAIT_BURST_OPT2 = 3'h1;
  localparam logic [2:0] WAIT_AFTER_IDLE = 3'h1;
  // refresh prescaler
  localparam logic [2:0] REF_DIV_CODE = 3'h0;
  localparam logic [3:0] REF_DIV_TEN = 4'hA;
  localparam logic [3:0] REF_DIV_OTHER = 4'hA;
  // mode programming word: bit positions
  localparam int R0_POS = 0;
  localparam int R1_POS = 1;
  localparam int R2_POS = 2;
  localparam int R3_POS = 3;
  localparam int R4_POS = 4;
  localparam int R5_POS = 5;
  localparam int R7_POS = 7;
  localparam int R8_POS = 8;
  localparam int C0_POS = 10;
  localparam int C4_POS = 14;
  localparam int C7_POS = 17;
  localparam int C8_POS = 18;
  localparam int C9_POS = 19;
  localparam int B0_POS = 20;
  localparam int B1_POS = 21;
  localparam int MODE_W = 22;
  // mode field values
  localparam logic [1:0] ROW_TIMING_VAL = 2'h3;
  localparam logic [1:0] ACK_TIMING_VAL = 2'h1;
  localparam logic [1:0] BURST_WAIT_VAL = 2'h0;
  localparam logic ACK_OUT_VAL = 1'h1;
  localparam logic PIPE_DIS_VAL = 1'h1;
  localparam logic [2:0] STROBE_GROUP_VAL = 3'h4;
  localparam logic ROW_SETUP_VAL = 1'h1;
  localparam logic ROW_HOLD_VAL = 1'h1;
  localparam logic WRITE_CAS_VAL = 1'h1;
  localparam logic ADDR_MODE_VAL = 1'h0;
  localparam logic BANK_SEL_VAL = 1'h1;
  localparam logic [MODE_W-1:0] MODE_RESET = 22'h0;
  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_OPEN, ST_PRECH} bdg_state_t;
endpackage

// [burst_page_mode_dram_glue_tb.sv]
// testbench: processor-side scenarios for the dram glue
`timescale 1ns/100ps
`default_nettype none
module burst_page_mode_dram_glue_tb;
  import bdg_pkg::*;
  logic clk = 0, rstn = 0, opt = 0, csN = 1, reqN = 1, bN = 1, refN = 1, dck = 0, pRdy = 1;
  logic slow = 0, wr = 0, arN, asN, irN, baN, ci, ecN, cas, tick, pV, ackN, ecSeen;
  logic [MODE_W-1:0] mode;
  logic [31:0] dd, pD;
  int failures = 0, n_compared = 0, cyc = 0, ciCnt = 0, ecLow = 0;
  // clock, delay clock at half rate, run limit
  initial forever #25 clk = ~clk;
  always @(negedge clk) dck <= ~dck;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      failures++;
      conclude();
    end
  end
  bdg_glue i_dut (.clk(clk), .rstn(rstn), .burstOption(opt), .chipSelectN(csN),
    .instrRequestN(reqN), .instrBurstRequestN(bN), .accessIsWrite(wr),
    .refreshRequestN(refN), .dataTransferAckN(ackN), .delayClockIn(dck), .dramData(dd),
    .accessRequestN(arN), .addrStrobeN(asN), .instrReadyN(irN), .instrBurstAckN(baN),
    .columnIncrement(ci), .earlyCasN(ecN), .columnAddrSelect(cas), .refreshTick(tick),
    .modeProgram(mode), .procDataValid(pV), .procDataReady(pRdy), .procData(pD));
  bdg_ctrl_model i_ctrl (.clk(clk), .rstn(rstn), .accessRequestN(arN), .columnIncrement(ci),
    .slow(slow), .dataTransferAckN(ackN), .dramData(dd));
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(negedge clk);
  endtask
  // wait for ready, noting early column strobe
  task automatic rdy(input int lim, output int n);
    n = 0;
    ecSeen = 0;
    ecLow = 0;
    do begin
      @(negedge clk);
      n++;
      if (ecN === 1'b0) begin
        ecSeen = 1;
        ecLow++;
      end
    end while (irN !== 1'b0 && n < lim);
  endtask
  task automatic word(input logic expCi, output int n);
    rdy(40, n);
    chk("word", 32'hC0DE0000 + 32'(ciCnt), pD);
    chk("column_increment", {31'h0, expCi}, {31'h0, ci});
    if (expCi) ciCnt++;
  endtask
  task automatic do_reset;
    rstn = 0;
    step(3);
    chk("rst outs", 32'h7, {29'h0, irN, arN, ecN});
    chk("rst mode", 32'h0, {10'h0, mode});
    chk("rst sel", 32'h2, {30'h0, asN, cas});
    rstn = 1;
    step(2);
    chk("mode", 32'h002F0187, {10'h0, mode});
  endtask
  task automatic run_opt(input logic o, output int ls, output int lg, output int lb);
    int x;
    do_reset;
    opt = o;
    ciCnt = 0;
    csN = 0;
    reqN = 0;
    word(1'b0, ls);
    reqN = 1;
    csN = 1;
    step(2);
    bN = 0;
    word(1'b1, lg);
    word(1'b1, lb);
    chk("ecas seen", 32'h1, {31'h0, ecSeen});
    bN = 1;
    step(3);
    bN = 0;
    word(1'b1, x);
    bN = 1;
    chk("gap", 32'(lg), 32'(x));
    chk("ecas gap", 32'h1, 32'(ecLow));
    step(3);
    wr = 1;
    bN = 0;
    word(1'b1, x);
    bN = 1;
    wr = 0;
    chk("ecas wr", 32'h0, 32'(ecLow));
    $display("burst option %0d done", o);
  endtask
  // row stays open, then a new request and a refresh each close it
  task automatic test_hold;
    int n;
    step(10);
    chk("row held", 32'h0, {31'h0, arN});
    chk("addr strobe", 32'h0, {31'h0, asN});
    chk("col select", 32'h1, {31'h0, cas});
    chk("back idle", 32'h0, {31'h0, baN});
    csN = 0;
    reqN = 0;
    step(1);
    chk("back req", 32'h1, {31'h0, baN});
    n = 0;
    while (arN !== 1'b1 && n < 20) begin step(1); n++; end
    n = 0;
    while (arN !== 1'b0 && n < 20) begin step(1); n++; end
    chk("prech", 32'h1, 32'(n >= 3));
    rdy(40, n);
    reqN = 1;
    csN = 1;
    step(3);
    refN = 0;
    step(4);
    chk("back ref", 32'h1, {31'h0, baN});
    n = 0;
    while (arN !== 1'b1 && n < 20) begin step(1); n++; end
    chk("ref release", 32'h1, {31'h0, arN});
    refN = 1;
    step(4);
    $display("row hold done");
  endtask
  // a stalled receiver withholds the third ready and loses nothing
  task automatic test_buffer;
    int n;
    pRdy = 0;
    csN = 0;
    reqN = 0;
    rdy(40, n);
    reqN = 1;
    csN = 1;
    step(2);
    bN = 0;
    rdy(40, n);
    rdy(30, n);
    chk("full stall", 32'd30, 32'(n));
    chk("head", 32'hC0DE0000, pD);
    pRdy = 1;
    rdy(40, n);
    chk("resume", 32'h0, {31'h0, irN});
    chk("next word", 32'hC0DE0001, pD);
    bN = 1;
    step(4);
    chk("drained", 32'h0, {31'h0, pV});
    $display("buffer done");
  endtask
  task automatic test_misc(input int ls);
    int n;
    do_reset;
    slow = 1;
    csN = 0;
    reqN = 0;
    rdy(60, n);
    slow = 0;
    chk("slow stall", 32'h1, 32'(n > ls));
    reqN = 1;
    step(4);
    reqN = 0;
    step(3);
    rstn = 0;
    step(1);
    chk("mid rst", 32'h7, {29'h0, irN, arN, ecN});
    reqN = 1;
    csN = 1;
    step(2);
    rstn = 1;
    n = 0;
    while (tick !== 1'b1 && n < 100) begin step(1); n++; end
    n = 0;
    do begin step(1); n++; end while (tick !== 1'b1 && n < 100);
    chk("tick gap", 32'd20, 32'(n));
    $display("slow ack, reset, tick done");
  endtask
  task automatic conclude;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // main sequence
  initial begin
    int s0, g0, b0, s1, g1, b1;
    run_opt(1'b0, s0, g0, b0);
    run_opt(1'b1, s1, g1, b1);
    chk("lat opt", 32'(b1 + 1), 32'(b0));
    chk("lat single", 32'(b1 + 3), 32'(s1));
    chk("lat gap", 32'(b1), 32'(g0));
    test_hold;
    test_buffer;
    test_misc(s1);
    conclude;
  end
endmodule
`default_nettype wire
